// ### fault_protection_interrupts.sv
// Fault supervision, interrupt flags and their register port.
`timescale 1ns/10ps

module fault_protection_interrupts
  import fault_irq_pkg::*;
(
  input  wire logic       i_clk_sys,        // System clock, 100 MHz.
  input  wire logic       i_sys_rst,        // Synchronous reset, active high.
  input  wire logic       i_uvlo,           // Undervoltage lockout level, async.
  input  wire logic       i_reg_wr,         // Register write strobe.
  input  wire logic       i_reg_rd,         // Register read strobe.
  input  wire logic [7:0] i_reg_addr,       // Register address.
  input  wire logic [7:0] i_reg_wdata,      // Register write data.
  input  wire logic       i_out_at_reg,     // Output at regulation level, async.
  input  wire logic       i_out_over,       // Output above overvoltage threshold, async.
  input  wire logic       i_out_recovered,  // Output back below recovery level, async.
  input  wire logic       i_die_hot,        // Die above shutdown limit, async.
  input  wire logic       i_die_warm,       // Die above recovery level, async.
  input  wire logic       i_out_short,      // Output below short level, async.
  input  wire logic [1:0] i_amb_main,       // Main sensor threshold outputs, async.
  input  wire logic [1:0] i_amb_second,     // Second sensor threshold outputs, async.
  output logic [7:0]      o_reg_rdata,      // Register read data.
  output logic            o_irq_out_n,      // Interrupt pin, active low.
  output logic            o_pump_en,        // Charge pump running.
  output logic            o_rout_raise,     // Raise gain-stage output resistance.
  output logic            o_sinks_en,       // Current sinks and functions running.
  output logic            o_low_power,      // Low-power state after a short.
  output logic            o_gain_downshift_block // Gain downshift blocked.
);

  // ---------------------------------------------------------------------------
  // Input synchronisers and edges
  // ---------------------------------------------------------------------------
  logic [11:0] raw_in, syn;
  logic [5:0]  edg;
  logic        uvlo_s, at_reg_s, over_s, recov_s, hot_s, warm_s, short_s;
  logic [1:0]  amb1_s, amb2_s;
  logic        ovg_entry, hot_rise, short_rise, amb1_chg, amb2_chg;

  assign raw_in = {i_uvlo, i_out_at_reg, i_out_over, i_out_recovered, i_die_hot,
                   i_die_warm, i_out_short, i_amb_main, i_amb_second, 1'b0};
  assign {uvlo_s, at_reg_s, over_s, recov_s, hot_s, warm_s, short_s} = syn[11:5];
  assign amb1_s = syn[4:3];
  assign amb2_s = syn[2:1];

  pin_sync #(.W(12)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_async   (raw_in),
    .o_sync    (syn)
  );

  edge_pulse #(.W(6)) u_edge (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_level   ({hot_s, short_s, amb1_s, amb2_s}),
    .i_any     (6'b001111),
    .o_pulse   (edg)
  );

  assign amb1_chg   = edg[3] | edg[2];
  assign amb2_chg   = edg[1] | edg[0];
  assign hot_rise   = edg[5];
  assign short_rise = edg[4];

  logic soft_rst;
  assign soft_rst = i_sys_rst | uvlo_s;

  // ---------------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction

  logic [7:0] mode_reg, next_mode;
  logic [4:0] flags, next_flags, enab, next_enab, clr, set_ev;
  logic       wr_exit;

  assign clr     = (i_reg_wr && hit(i_reg_addr, ADDR_FLAGS)) ? i_reg_wdata[4:0] : 5'h00;
  assign wr_exit = i_reg_wr && hit(i_reg_addr, ADDR_MODE) && i_reg_wdata[BIT_STANDBY_EXIT];

  // ---------------------------------------------------------------------------
  // Power state machine
  // ---------------------------------------------------------------------------
  pwr_state_t state, next_state;
  logic       ovg, next_ovg;
  logic [MASK_CNT_W-1:0] mask_cnt, next_mask_cnt;
  logic       short_armed;
  logic       therm_trip, short_trip;

  assign short_armed = (mask_cnt == '0);
  assign therm_trip  = hot_rise && (state != ST_STANDBY);
  assign short_trip  = short_s && short_armed && (state == ST_RUN);

  always_comb begin
    next_state    = state;
    next_ovg      = ovg;
    next_mode     = mode_reg;
    next_mask_cnt = (mask_cnt != '0) ? mask_cnt - 1'b1 : mask_cnt;
    if (i_reg_wr && hit(i_reg_addr, ADDR_MODE)) begin
      next_mode = i_reg_wdata & MODE_MASK;
    end
    case (state)
      ST_STANDBY: begin
        if (mode_reg[BIT_STANDBY_EXIT] && !warm_s && !hot_s) begin
          next_state    = ST_RUN;
          next_mask_cnt = MASK_CNT_W'(SHORT_MASK_CYC);
        end
      end
      ST_RUN: begin
        if (over_s) begin
          next_ovg = 1'b1;
        end else if (recov_s) begin
          next_ovg = 1'b0;
        end
        if (!mode_reg[BIT_STANDBY_EXIT]) begin
          next_state = ST_STANDBY;
        end
        if (short_trip) begin
          next_state = ST_FAULT;
        end
      end
      ST_FAULT: begin
        if (wr_exit) begin
          next_state    = ST_RUN;
          next_mask_cnt = MASK_CNT_W'(SHORT_MASK_CYC);
        end else if (!mode_reg[BIT_STANDBY_EXIT]) begin
          next_state = ST_STANDBY;
        end
      end
      default: next_state = ST_STANDBY;
    endcase
    if (therm_trip || hot_s) begin
      next_state = ST_STANDBY;
      next_mode[BIT_STANDBY_EXIT] = 1'b0;
    end
    if (next_state != ST_RUN) begin
      next_ovg = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Flags and enables
  // ---------------------------------------------------------------------------
  always_comb begin
    set_ev = '0;
    set_ev[BIT_AMB]   = amb1_chg;
    set_ev[BIT_AMB2]  = amb2_chg;
    set_ev[BIT_OVG]   = next_ovg && !ovg;
    set_ev[BIT_THERM] = therm_trip || (flags[BIT_THERM] && clr[BIT_THERM] && warm_s);
    set_ev[BIT_SHORT] = short_trip && (state == ST_RUN);
    next_flags = (flags & ~clr) | set_ev;
    next_enab  = enab;
    if (i_reg_wr && hit(i_reg_addr, ADDR_ENAB)) begin
      next_enab = i_reg_wdata[4:0];
    end
  end

  logic [7:0] next_rdata;
  always_comb begin
    case (1'b1)
      hit(i_reg_addr, ADDR_MODE):  next_rdata = mode_reg;
      hit(i_reg_addr, ADDR_FLAGS): next_rdata = {PAD_ZERO, flags};
      hit(i_reg_addr, ADDR_ENAB):  next_rdata = {PAD_ZERO, enab};
      default:                     next_rdata = 8'h00;
    endcase
    if (!i_reg_rd) begin
      next_rdata = o_reg_rdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (soft_rst) begin
      state                  <= ST_STANDBY;
      ovg                    <= 1'b0;
      mask_cnt               <= '0;
      mode_reg               <= RESET_MODE;
      flags                  <= RESET_FLAGS;
      enab                   <= RESET_ENAB;
      o_reg_rdata            <= 8'h00;
      o_irq_out_n            <= 1'b1;
      o_pump_en              <= 1'b0;
      o_rout_raise           <= 1'b0;
      o_sinks_en             <= 1'b0;
      o_low_power            <= 1'b0;
      o_gain_downshift_block <= 1'b0;
    end else begin
      state                  <= next_state;
      ovg                    <= next_ovg;
      mask_cnt               <= next_mask_cnt;
      mode_reg               <= next_mode;
      flags                  <= next_flags;
      enab                   <= next_enab;
      o_reg_rdata            <= next_rdata;
      o_irq_out_n            <= ~|(next_flags & next_enab);
      o_pump_en              <= (next_state == ST_RUN) && !next_ovg;
      o_rout_raise           <= (next_state == ST_RUN) && at_reg_s;
      o_sinks_en             <= (next_state == ST_RUN);
      o_low_power            <= (next_state == ST_FAULT);
      o_gain_downshift_block <= next_mode[BIT_GAIN_BLOCK];
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_irq_pin;
    @(posedge i_clk_sys) disable iff (soft_rst) o_irq_out_n == ~|(flags & enab);
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("irq pin mismatch");

  property p_sticky;
    @(posedge i_clk_sys) disable iff (soft_rst)
      ($past(flags) & ~$past(clr)) == ($past(flags) & ~$past(clr) & flags);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");

  property p_zero_write;
    @(posedge i_clk_sys) disable iff (soft_rst)
      (!i_reg_wr) |=> ((flags & $past(flags)) == $past(flags));
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("flag cleared without write");

  property p_ovg_flag;
    @(posedge i_clk_sys) disable iff (soft_rst) $rose(ovg) |-> flags[BIT_OVG];
  endproperty
  a_ovg_flag: assert property (p_ovg_flag) else $error("overvoltage flag missing");

  property p_pump_off;
    @(posedge i_clk_sys) disable iff (soft_rst) ovg |-> (!o_pump_en && o_sinks_en);
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump not paused");

  property p_therm;
    @(posedge i_clk_sys) disable iff (soft_rst)
      therm_trip |=> (state == ST_STANDBY) && flags[BIT_THERM];
  endproperty
  a_therm: assert property (p_therm) else $error("thermal shutdown missing");

  property p_no_cool_flag;
    @(posedge i_clk_sys) disable iff (soft_rst)
      !therm_trip |=> !$rose(flags[BIT_THERM]);
  endproperty
  a_no_cool_flag: assert property (p_no_cool_flag) else $error("overtemp flag without trip");

  property p_short_mask;
    @(posedge i_clk_sys) disable iff (soft_rst)
      (state != ST_RUN) ##1 (state == ST_RUN) |-> mask_cnt != '0;
  endproperty
  a_short_mask: assert property (p_short_mask) else $error("short not masked");

  property p_short;
    @(posedge i_clk_sys) disable iff (soft_rst)
      short_trip |=> o_low_power && flags[BIT_SHORT];
  endproperty
  a_short: assert property (p_short) else $error("short guard missing");

  property p_rsvd;
    @(posedge i_clk_sys) disable iff (soft_rst)
      (i_reg_rd && !hit(i_reg_addr, ADDR_MODE)) |=> o_reg_rdata[7:5] == PAD_ZERO;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");

  c_ovg:   cover property (@(posedge i_clk_sys) $rose(ovg));
  c_therm: cover property (@(posedge i_clk_sys) therm_trip);
  c_short: cover property (@(posedge i_clk_sys) short_trip);
  c_irq:   cover property (@(posedge i_clk_sys) $fell(o_irq_out_n));

endmodule // fault_protection_interrupts

// ### fault_irq_pkg.sv
// Package of register offsets, field positions and timing constants for fault supervision.
package fault_irq_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE  = 8'h01;
  localparam logic [7:0] ADDR_FLAGS = 8'h02;
  localparam logic [7:0] ADDR_ENAB  = 8'h03;

  // Mode register fields.
  localparam int BIT_GAIN_BLOCK   = 3;
  localparam int BIT_STANDBY_EXIT = 5;

  // Flag and enable field positions.
  localparam int BIT_AMB   = 0;
  localparam int BIT_AMB2  = 1;
  localparam int BIT_OVG   = 2;
  localparam int BIT_THERM = 3;
  localparam int BIT_SHORT = 4;
  localparam int NUM_FLAGS = 5;

  localparam logic [7:0] RESET_MODE  = 8'h00;
  localparam logic [4:0] RESET_FLAGS = 5'h00;
  localparam logic [4:0] RESET_ENAB  = 5'h00;
  localparam logic [2:0] PAD_ZERO    = 3'h0;
  localparam logic [7:0] MODE_MASK   = 8'h7f;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ        = 100;
  localparam int SHORT_MASK_US  = 4000;
  localparam int SHORT_MASK_CYC = SHORT_MASK_US * CLK_MHZ;
  localparam int MASK_CNT_W     = 19;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b001,
    ST_RUN     = 3'b010,
    ST_FAULT   = 3'b100
  } pwr_state_t;

endpackage

// ### pin_sync.sv
// Three-stage input synchroniser with agreement of the last two stages.
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk_sys,  // System clock.
  input  wire logic         i_sys_rst,  // Synchronous reset.
  input  wire logic [W-1:0] i_async,    // Raw inputs.
  output logic      [W-1:0] o_sync      // Filtered inputs.
);
  logic [W-1:0] s1, s2, s3, next_sync;

  always_comb begin
    next_sync = o_sync;
    for (int k = 0; k < W; k++) begin
      if (s2[k] == s3[k]) begin
        next_sync[k] = s3[k];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      o_sync <= '0;
    end else begin
      s1     <= i_async;
      s2     <= s1;
      s3     <= s2;
      o_sync <= next_sync;
    end
  end
endmodule // pin_sync

// ### edge_pulse.sv
// Rising or any-edge pulse detector on synchronised levels.
`timescale 1ns/10ps
module edge_pulse #(
  parameter int W = 1
) (
  input  wire logic         i_clk_sys,  // System clock.
  input  wire logic         i_sys_rst,  // Synchronous reset.
  input  wire logic [W-1:0] i_level,    // Synchronised levels.
  input  wire logic [W-1:0] i_any,      // One selects both edges per bit.
  output logic      [W-1:0] o_pulse     // One-cycle pulses.
);
  logic [W-1:0] prev;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_edge
      assign o_pulse[g] = i_any[g] ? (i_level[g] ^ prev[g]) : (i_level[g] & ~prev[g]);
    end
  endgenerate

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      prev <= '0;
    end else begin
      prev <= i_level;
    end
  end
endmodule // edge_pulse

// ### irq_host_model.sv
// Host processor model that issues register writes and reads.
`timescale 1ns/10ps
module irq_host_model
  import fault_irq_pkg::*;
(
  input  wire logic       i_clk_sys,    // System clock.
  input  wire logic [7:0] i_reg_rdata,  // Read data from the device.
  output logic            o_reg_wr,     // Write strobe.
  output logic            o_reg_rd,     // Read strobe.
  output logic [7:0]      o_reg_addr,   // Register address.
  output logic [7:0]      o_reg_wdata   // Write data.
);
  initial begin
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_addr  = 8'h00;
    o_reg_wdata = 8'h00;
  end

  // Released lines show the inverse so stale values are never trusted.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clk_sys);
    o_reg_wr    <= 1'b1;
    o_reg_addr  <= addr;
    o_reg_wdata <= data;
    @(posedge i_clk_sys);
    o_reg_wr    <= 1'b0;
    o_reg_addr  <= ~addr;
    o_reg_wdata <= ~data;
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge i_clk_sys);
    o_reg_rd   <= 1'b1;
    o_reg_addr <= addr;
    @(posedge i_clk_sys);
    o_reg_rd   <= 1'b0;
    o_reg_addr <= ~addr;
    #1;
    data = i_reg_rdata;
  endtask

  task automatic clear_flags(input logic [7:0] mask);
    write_reg(ADDR_FLAGS, mask);
  endtask

  task automatic start_dev(input logic gain_blk);
    write_reg(ADDR_MODE, {2'b00, 1'b1, 1'b0, gain_blk, 3'b000});
  endtask
endmodule // irq_host_model

// ### fault_protection_interrupts_bench.sv
// Self-checking bench for fault supervision and interrupt flags.
`timescale 1ns/10ps
module fault_protection_interrupts_bench
  import fault_irq_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       uvlo, wr, rd, at_reg, over, recov, hot, warm, shrt;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] amb_main, amb_sec;
  logic       irq_n, pump, rout, sinks, lowp, gblk;
  int         n_fail = 0;
  int         num_checks = 0;
  int         cyc = 0;
  integer     seed;
  logic [7:0] d;
  int         fb;

  always #5 clk = ~clk;

  fault_protection_interrupts fault_protection_interrupts_inst (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_uvlo(uvlo), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_out_at_reg(at_reg), .i_out_over(over),
    .i_out_recovered(recov), .i_die_hot(hot), .i_die_warm(warm), .i_out_short(shrt),
    .i_amb_main(amb_main), .i_amb_second(amb_sec), .o_reg_rdata(rdata),
    .o_irq_out_n(irq_n), .o_pump_en(pump), .o_rout_raise(rout), .o_sinks_en(sinks),
    .o_low_power(lowp), .o_gain_downshift_block(gblk));

  irq_host_model irq_host_model_inst (
    .i_clk_sys(clk), .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_reg_addr(addr), .o_reg_wdata(wdata));

  function automatic logic [7:0] flag_bit(input int b);
    return 8'h01 << b;
  endfunction

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] got;
    irq_host_model_inst.read_reg(a, got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t reg %h got %h exp %h", $time, a, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp, input string name);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t pin %s got %b exp %b", $time, name, got, exp);
    end
  endtask

  // Async inputs pass a three-flop filter before they act.
  task automatic wait_sync();
    repeat (8) @(posedge clk);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      n_fail++;
      $display("[FAIL] %0t run did not finish", $time);
      end_sim();
    end
  end

  initial begin
    seed = 32'h953c2b0d;
    {uvlo, at_reg, over, recov, hot, warm, shrt} = 7'h00;
    amb_main = 2'h0;
    amb_sec  = 2'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk_reg(ADDR_MODE, RESET_MODE);
    chk_reg(ADDR_FLAGS, {PAD_ZERO, RESET_FLAGS});
    chk_reg(ADDR_ENAB, {PAD_ZERO, RESET_ENAB});
    chk_pin(irq_n, 1'b1, "irq");
    irq_host_model_inst.write_reg(8'h07, 8'hff);
    chk_reg(8'h07, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      irq_host_model_inst.write_reg(ADDR_ENAB, d);
      chk_reg(ADDR_ENAB, d & 8'h1f);
    end
    irq_host_model_inst.write_reg(ADDR_ENAB, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      fb = (i % 2) ? BIT_AMB2 : BIT_AMB;
      if (i == 4) irq_host_model_inst.write_reg(ADDR_ENAB, 8'h1f);
      @(posedge clk);
      if (i % 2) amb_sec[(i / 2) % 2] <= ~amb_sec[(i / 2) % 2];
      else amb_main[(i / 2) % 2] <= ~amb_main[(i / 2) % 2];
      wait_sync();
      chk_reg(ADDR_FLAGS, flag_bit(fb));
      chk_pin(irq_n, (i < 4), "irq");
      irq_host_model_inst.write_reg(ADDR_FLAGS, 8'h00);
      chk_reg(ADDR_FLAGS, flag_bit(fb));
      irq_host_model_inst.clear_flags(flag_bit(fb));
      chk_reg(ADDR_FLAGS, 8'h00);
      chk_pin(irq_n, 1'b1, "irq");
    end
    $display("test ambient done");
    @(posedge clk);
    shrt <= 1'b1;
    irq_host_model_inst.start_dev(1'b1);
    wait_sync();
    chk_pin(sinks, 1'b1, "sinks");
    chk_pin(pump, 1'b1, "pump");
    chk_pin(gblk, 1'b1, "gain block");
    chk_pin(lowp, 1'b0, "low power");
    chk_reg(ADDR_MODE, 8'h28);
    @(posedge clk);
    at_reg <= 1'b1;
    wait_sync();
    chk_pin(rout, 1'b1, "rout");
    chk_reg(ADDR_FLAGS, 8'h00);
    @(posedge clk);
    at_reg <= 1'b0;
    shrt   <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      @(posedge clk);
      over  <= 1'b1;
      recov <= 1'b0;
      wait_sync();
      chk_pin(pump, 1'b0, "pump");
      chk_pin(sinks, 1'b1, "sinks");
      chk_pin(rout, 1'b0, "rout");
      chk_reg(ADDR_FLAGS, flag_bit(BIT_OVG));
      chk_pin(irq_n, 1'b0, "irq");
      @(posedge clk);
      over  <= 1'b0;
      recov <= 1'b1;
      wait_sync();
      chk_pin(pump, 1'b1, "pump");
      irq_host_model_inst.clear_flags(8'hff);
      chk_reg(ADDR_FLAGS, 8'h00);
    end
    $display("test overvoltage done");
    @(posedge clk);
    hot  <= 1'b1;
    warm <= 1'b1;
    wait_sync();
    chk_pin(sinks, 1'b0, "sinks");
    chk_pin(pump, 1'b0, "pump");
    chk_reg(ADDR_FLAGS, flag_bit(BIT_THERM));
    chk_reg(ADDR_MODE, 8'h08);
    @(posedge clk);
    hot <= 1'b0;
    wait_sync();
    irq_host_model_inst.clear_flags(flag_bit(BIT_THERM));
    chk_reg(ADDR_FLAGS, flag_bit(BIT_THERM));
    irq_host_model_inst.start_dev(1'b0);
    wait_sync();
    chk_pin(sinks, 1'b0, "sinks");
    @(posedge clk);
    warm <= 1'b0;
    wait_sync();
    irq_host_model_inst.clear_flags(flag_bit(BIT_THERM));
    wait_sync();
    chk_reg(ADDR_FLAGS, 8'h00);
    irq_host_model_inst.start_dev(1'b0);
    wait_sync();
    chk_pin(sinks, 1'b1, "sinks");
    $display("test thermal done");
    @(posedge clk);
    uvlo <= 1'b1;
    wait_sync();
    @(posedge clk);
    uvlo <= 1'b0;
    wait_sync();
    chk_reg(ADDR_ENAB, 8'h00);
    chk_reg(ADDR_MODE, 8'h00);
    chk_pin(sinks, 1'b0, "sinks");
    $display("test undervoltage done");
    end_sim();
  end
endmodule // fault_protection_interrupts_bench
